// ### rtl/sdc_top.sv
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module sdc_top
	import sdc_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC
) (
	input  wire logic        SYS_CLK_IN,
	input  wire logic        ARST_N_IN,
	input  wire logic        CE_IN,
	input  wire logic        AXI_AWVALID_IN,
	output logic             AXI_AWREADY_OUT,
	input  wire logic [31:0] AXI_AWADDR_IN,
	input  wire logic        AXI_WVALID_IN,
	output logic             AXI_WREADY_OUT,
	input  wire logic [31:0] AXI_WDATA_IN,
	input  wire logic [3:0]  AXI_WSTRB_IN,
	output logic             AXI_BVALID_OUT,
	input  wire logic        AXI_BREADY_IN,
	output logic      [1:0]  AXI_BRESP_OUT,
	input  wire logic        AXI_ARVALID_IN,
	output logic             AXI_ARREADY_OUT,
	input  wire logic [31:0] AXI_ARADDR_IN,
	output logic             AXI_RVALID_OUT,
	input  wire logic        AXI_RREADY_IN,
	output logic      [31:0] AXI_RDATA_OUT,
	output logic      [1:0]  AXI_RRESP_OUT,
	input  wire sdc_lnk_t    LINK_IN,
	input  wire sdc_mdm_t    MODEM_IN,
	output logic             DTR_OUT,
	output logic             DIAL_STB_OUT,
	output logic      [7:0]  DIAL_ADDR_OUT,
	output logic             RX_OK_OUT,
	input  wire logic        TX_BUSY_IN,
	input  wire logic        TX_UNDERRUN_IN,
	output logic             TX_ABORT_OUT,
	output logic             IRQ_OUT
);
	typedef struct packed {
		sdc_lnk_t [1:0] sy;
		sdc_mdm_t [1:0] sm;
		logic           lclk_p;
		logic           frm_p;
		logic [15:0]    crc;
		logic [18:0]    bits;
		logic           abt;
		logic           rx_ok;
		logic           aw_v;
		logic [7:0]     aw;
		logic           w_v;
		logic [31:0]    wd;
		logic [3:0]     ws;
		logic           bv;
		logic [1:0]     br;
		logic           rv;
		logic [31:0]    rd;
		logic [1:0]     rr;
		logic [15:0]    cmd;
		logic [15:0]    con;
		logic [15:0]    dis;
		logic [15:0]    noa;
		logic [15:0]    mxf;
		logic [3:0]     rty;
		logic [7:0]     adr;
		logic [3:0]     ckp;
		logic           ans_en;
		sdc_st_t        st;
		logic           ans;
		logic           dtr;
		logic [15:0]    tm;
		logic [9:0]     tms;
		logic           stb;
		logic           blk;
		logic           ta;
		logic [7:0]     tadr;
		logic [3:0]     tcnt;
		logic [15:0]    ttm;
		logic [17:0]    pre;
		logic [9:0]     msc;
		logic [31:0]    up;
		logic [NIRQ-1:0] ist;
		logic [NIRQ-1:0] imsk;
		logic           txa;
	} sdc_core_st_t;

	sdc_core_st_t    q;
	sdc_core_st_t    d;
	logic [NCNT-1:0] ev;
	logic [31:0]     cnt [NCNT];
	logic            cnt_clr;
	logic            ms_tk;
	logic            s_tk;
	logic            wr;
	logic            rd_go;
	logic            dial_w;
	logic            hup_w;
	logic            blk_c;
	logic [NIRQ-1:0] iev;
	logic [7:0]      ra;
	logic [2:0]      ci;
	sdc_lnk_t        lk;
	sdc_mdm_t        md;

	function automatic logic [31:0] wm(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [1:0] ckt(input logic on, input logic fit);
		return !fit ? CK_UND : (on ? CK_ON : CK_OFF);
	endfunction

	////////////////////////////////////////////////////////////////
	// second stage only: first stage is read by nothing else
	assign lk     = q.sy[1];
	assign md     = q.sm[1];
	assign ms_tk  = (q.pre == 18'(MS_CYCLES - 1));
	assign s_tk   = ms_tk && (q.msc == MS_TOP);
	assign wr     = q.aw_v && q.w_v && !q.bv;
	assign rd_go  = AXI_ARVALID_IN && !q.rv;
	assign ra     = AXI_ARADDR_IN[7:0];
	assign ci     = 3'((ra - A_CNT) >> 2);
	assign dial_w = wr && q.aw == A_CTRL && q.ws[0] && q.wd[C_DIAL];
	assign hup_w  = wr && q.aw == A_CTRL && q.ws[0] && q.wd[C_HUP];
	assign cnt_clr = wr && q.aw == A_CTRL && q.ws[0] && q.wd[C_PRST];
	// retry 0 forbids every call; a zero period leaves pacing to the modem
	assign blk_c  = (q.rty == '0)
		|| (q.ta && q.tadr == q.adr && q.tcnt >= q.rty && q.noa != '0);

	always_comb begin
		d        = q;
		ev       = '0;
		iev      = '0;
		d.stb    = 1'b0;
		d.rx_ok  = 1'b0;
		d.txa    = 1'b0;
		d.sy     = {q.sy[0], LINK_IN};
		d.sm     = {q.sm[0], MODEM_IN};
		d.pre    = ms_tk ? '0 : q.pre + 18'h1;
		if (ms_tk) begin
			d.msc = (q.msc == MS_TOP) ? '0 : q.msc + 10'h1;
		end
		d.up = cnt_clr ? '0 : q.up + {31'h0, s_tk};

		////////////////////////////////////////////////////////////
		// frame screen: bits sampled on rising link clock
		d.lclk_p = lk.clk;
		if (lk.clk && !q.lclk_p) begin
			d.frm_p = lk.frm;
			if (lk.frm) begin
				d.crc  = {1'b0, q.crc[15:1]} ^ ((q.crc[0] ^ lk.dat) ? CRC_POLY : '0);
				d.bits = (q.bits == '1) ? q.bits : q.bits + 19'h1;
				d.abt  = q.abt | lk.abt;
			end else if (q.frm_p) begin
				if (q.abt) begin
					ev[E_ABT] = 1'b1;
				end else if (q.bits < MIN_BITS) begin
					ev[E_SHT] = 1'b1;
				end else if (q.bits[2:0] != '0) begin
					ev[E_ALN] = 1'b1;
				end else if (q.bits > {q.mxf, 3'b000}) begin
					ev[E_LNG] = 1'b1;
				end else if (q.crc != CRC_GOOD) begin
					ev[E_CRC] = 1'b1;
				end else begin
					d.rx_ok = 1'b1;
				end
				d.crc  = CRC_INIT;
				d.bits = '0;
				d.abt  = 1'b0;
			end
		end
		ev[E_UND] = TX_UNDERRUN_IN;
		if (wr && q.aw == A_CTRL && q.ws[0] && q.wd[C_TXA] && TX_BUSY_IN) begin
			d.txa     = 1'b1;
			ev[E_OAB] = 1'b1;
		end

		////////////////////////////////////////////////////////////
		// no-answer window runs from the first attempt
		if (s_tk && q.ta) begin
			d.ttm = q.ttm + 16'h1;
			if (q.ttm + 16'h1 >= q.noa) begin
				d.ta = 1'b0;
			end
		end
		if (q.st == S_DLY && ms_tk && q.tm != '1) begin
			d.tm = q.tm + 16'h1;
		end
		if ((q.st == S_CALL || q.st == S_HUP) && ms_tk) begin
			d.tms = (q.tms == MS_TOP) ? '0 : q.tms + 10'h1;
			if (q.tms == MS_TOP && q.tm != '1) begin
				d.tm = q.tm + 16'h1;
			end
		end

		unique case (q.st)
			S_IDLE: begin
				if (dial_w) begin
					if (blk_c) begin
						d.blk      = 1'b1;
						iev[I_BLK] = 1'b1;
					end else begin
						d.blk = 1'b0;
						d.ans = 1'b0;
						d.st  = S_DLY;
						if (q.ta && q.tadr == q.adr) begin
							d.tcnt = q.tcnt + 4'h1;
						end else begin
							d.ta   = 1'b1;
							d.tadr = q.adr;
							d.tcnt = 4'h1;
							d.ttm  = '0;
						end
					end
				end else if (md.ring && q.ans_en) begin
					d.ans = 1'b1;
					d.st  = S_DLY;
				end
			end
			S_DLY: begin
				if (hup_w) begin
					d.st = S_HUP;
				end else if (q.cmd == '0 ? md.cts : q.tm >= q.cmd) begin
					d.st  = S_CALL;
					d.stb = !q.ans;
				end
			end
			S_CALL: begin
				if (md.dcd) begin
					d.st      = S_UP;
					iev[I_UP] = 1'b1;
					if (!q.ans) begin
						d.ta = 1'b0;
					end
				end else if (hup_w) begin
					d.st = S_HUP;
				end else if (q.con != '0 && q.tm >= q.con) begin
					d.st        = S_HUP;
					iev[I_FAIL] = 1'b1;
				end
			end
			S_UP: begin
				if (!md.dcd || hup_w) begin
					d.st = S_HUP;
				end
			end
			S_HUP: begin
				if (q.dis == '0 ? (!md.cts && !md.dsr) : q.tm >= q.dis) begin
					d.st = S_IDLE;
				end
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase
		if (d.st != q.st) begin
			d.tm  = '0;
			d.tms = '0;
		end
		d.dtr = (d.st == S_DLY || d.st == S_CALL || d.st == S_UP);

		////////////////////////////////////////////////////////////
		// register slave: write answers one cycle after both halves are in
		if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
			d.aw_v = 1'b1;
			d.aw   = AXI_AWADDR_IN[7:0];
		end
		if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
			d.w_v = 1'b1;
			d.wd  = AXI_WDATA_IN;
			d.ws  = AXI_WSTRB_IN;
		end
		if (q.bv && AXI_BREADY_IN) begin
			d.bv = 1'b0;
		end
		if (wr) begin
			d.aw_v = 1'b0;
			d.w_v  = 1'b0;
			d.bv   = 1'b1;
			d.br   = RESP_OK;
			case (q.aw)
				A_CTRL: d.ans_en = q.ws[0] ? q.wd[C_ANS] : q.ans_en;
				A_CMD:  d.cmd    = 16'(wm({16'h0, q.cmd}, q.wd, q.ws));
				A_CON:  d.con    = 16'(wm({16'h0, q.con}, q.wd, q.ws));
				A_DIS:  d.dis    = 16'(wm({16'h0, q.dis}, q.wd, q.ws));
				A_NOA:  d.noa    = 16'(wm({16'h0, q.noa}, q.wd, q.ws));
				A_MXF:  d.mxf    = 16'(wm({16'h0, q.mxf}, q.wd, q.ws));
				A_RTY:  d.rty    = 4'(wm({28'h0, q.rty}, q.wd, q.ws));
				A_ADR:  d.adr    = 8'(wm({24'h0, q.adr}, q.wd, q.ws));
				A_CKP:  d.ckp    = 4'(wm({28'h0, q.ckp}, q.wd, q.ws));
				A_IMSK: d.imsk   = NIRQ'(wm({27'h0, q.imsk}, q.wd, q.ws));
				default: d.br    = RESP_ERR;
			endcase
		end
		if (q.rv && AXI_RREADY_IN) begin
			d.rv = 1'b0;
		end
		iev[I_RX] = |ev[E_ABT:E_CRC];
		iev[I_TX] = ev[E_UND] | ev[E_OAB];
		// a read clears the sticky bits, yet an event in that cycle survives
		d.ist = q.ist | iev;
		if (rd_go) begin
			d.rv = 1'b1;
			d.rr = RESP_OK;
			d.rd = '0;
			case (ra)
				A_CTRL: d.rd[C_ANS] = q.ans_en;
				A_CMD:  d.rd[15:0]  = q.cmd;
				A_CON:  d.rd[15:0]  = q.con;
				A_DIS:  d.rd[15:0]  = q.dis;
				A_NOA:  d.rd[15:0]  = q.noa;
				A_MXF:  d.rd[15:0]  = q.mxf;
				A_RTY:  d.rd[3:0]   = q.rty;
				A_ADR:  d.rd[7:0]   = q.adr;
				A_CKP:  d.rd[3:0]   = q.ckp;
				A_STAT: d.rd[11:0]  = {ckt(q.dtr, q.ckp[0]), ckt(md.cts, q.ckp[1]),
					ckt(md.dsr, q.ckp[2]), ckt(md.dcd, q.ckp[3]), q.blk, q.st};
				A_IST: begin
					d.rd[NIRQ-1:0] = q.ist;
					d.ist          = iev;
				end
				A_IMSK: d.rd[NIRQ-1:0] = q.imsk;
				A_UP:   d.rd           = q.up;
				default: begin
					if (ra >= A_CNT && ra < A_UP && ra[1:0] == 2'b00) begin
						d.rd = cnt[ci];
					end else begin
						d.rr = RESP_ERR;
					end
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			q      <= '0;
			q.crc  <= CRC_INIT;
			q.cmd  <= CMD_RST;
			q.con  <= CON_RST;
			q.dis  <= DIS_RST;
			q.noa  <= NOA_RST;
			q.mxf  <= MXF_RST;
			q.rty  <= RTY_RST;
			q.ckp  <= CKP_RST;
			q.st   <= S_IDLE;
		end else if (CE_IN) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////
	for (genvar g = 0; g < NCNT; g++) begin : g_cnt
		sdc_cnt u_cnt (
			.clk_in   (SYS_CLK_IN),
			.rst_n_in (ARST_N_IN),
			.ce_in    (CE_IN),
			.clr_in   (cnt_clr),
			.inc_in   (ev[g]),
			.cnt_out  (cnt[g])
		);
	end

	assign AXI_AWREADY_OUT = !q.aw_v && !q.bv;
	assign AXI_WREADY_OUT  = !q.w_v && !q.bv;
	assign AXI_BVALID_OUT  = q.bv;
	assign AXI_BRESP_OUT   = q.br;
	assign AXI_ARREADY_OUT = !q.rv;
	assign AXI_RVALID_OUT  = q.rv;
	assign AXI_RDATA_OUT   = q.rd;
	assign AXI_RRESP_OUT   = q.rr;
	assign DTR_OUT         = q.dtr;
	assign DIAL_STB_OUT    = q.stb;
	assign DIAL_ADDR_OUT   = q.tadr;
	assign RX_OK_OUT       = q.rx_ok;
	assign TX_ABORT_OUT    = q.txa;
	assign IRQ_OUT         = |(q.ist & q.imsk);

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	sequence s_dly_done;
		q.st == S_DLY ##1 q.st == S_CALL;
	endsequence
	sequence s_hup_done;
		q.st == S_HUP ##1 q.st == S_IDLE;
	endsequence

	property p_cmd;
		s_dly_done |-> ($past(q.cmd) == '0 || $past(q.tm) >= $past(q.cmd));
	endproperty
	a_cmd: assert property (p_cmd) else $error("call before command delay");

	property p_cts;
		s_dly_done |-> ($past(q.cmd) != '0 || $past(md.cts));
	endproperty
	a_cts: assert property (p_cts) else $error("command without clear-to-send");

	property p_con;
		(CE_IN && q.st == S_CALL && !md.dcd && q.con != '0 && q.tm >= q.con) |=> q.st == S_HUP;
	endproperty
	a_con: assert property (p_con) else $error("connect timeout missed");

	property p_nocon;
		(CE_IN && q.st == S_CALL && !md.dcd && !hup_w && q.con == '0) |=> q.st == S_CALL;
	endproperty
	a_nocon: assert property (p_nocon) else $error("own timeout with zero interval");

	property p_dis;
		s_hup_done |-> ($past(q.dis) == '0 ? (!$past(md.cts) && !$past(md.dsr))
			: $past(q.tm) >= $past(q.dis));
	endproperty
	a_dis: assert property (p_dis) else $error("idle before disconnect wait");

	property p_hold;
		(CE_IN && q.st == S_HUP && q.dis == '0 && (md.cts || md.dsr)) |=> (q.st == S_HUP && !DTR_OUT);
	endproperty
	a_hold: assert property (p_hold) else $error("left hangup before modem dropped its lines");

	property p_blk;
		(CE_IN && q.st == S_IDLE && dial_w && blk_c) |=> (q.st == S_IDLE && q.blk && q.ist[I_BLK]);
	endproperty
	a_blk: assert property (p_blk) else $error("blocked call went out");

	property p_first;
		(CE_IN && q.st == S_IDLE && dial_w && !blk_c && !(q.ta && q.tadr == q.adr))
			|=> (q.ta && q.tcnt == 4'h1 && q.ttm == '0);
	endproperty
	a_first: assert property (p_first) else $error("window not started on first try");

	property p_drop;
		(CE_IN && |ev[E_ABT:E_CRC]) |=> !RX_OK_OUT;
	endproperty
	a_drop: assert property (p_drop) else $error("bad frame passed");
endmodule

// ### rtl/sdc_pkg.sv
package sdc_pkg;
	// Notes on behaviour
	// - after raising terminal-ready, wait the command delay in ms before calling or answering
	// - an outgoing call gets the connect interval in seconds, then counts as failed
	// - connect interval of zero: no own timeout, the modem decides
	// - after dropping terminal-ready, wait the disconnect interval before any call
	// - disconnect interval of zero: wait until the modem drops clear-to-send and data-set-ready
	// - at most the retry limit of calls to one silent address per no-answer period (only the address of the last call placed is tracked)
	// - once the limit is hit, block calls to that address until the period expires (a call to another address ends the block)
	// - the no-answer period starts at the first attempt to the address
	// - drop frames with a bad check sequence and count them
	// - drop frames whose bit length is not a whole number of bytes and count them
	// - drop frames shorter than two bytes and count them
	// - drop frames longer than the configured maximum size and count them
	// - count every received frame that ends in an abort
	// - abort the frame in transmission on request and count each abort sent
	// - report terminal-ready, clear-to-send, data-set-ready and carrier as on, off or undefined when not fitted

	localparam int CLK_HZ   = 200_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYC   = CLK_HZ / MS_PER_S;
	localparam logic [9:0] MS_TOP = 10'(MS_PER_S - 1);

	////////////////////////////////////////////////////////////////
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD  = 8'h04;
	localparam logic [7:0] A_CON  = 8'h08;
	localparam logic [7:0] A_DIS  = 8'h0c;
	localparam logic [7:0] A_RTY  = 8'h10;
	localparam logic [7:0] A_NOA  = 8'h14;
	localparam logic [7:0] A_MXF  = 8'h18;
	localparam logic [7:0] A_ADR  = 8'h1c;
	localparam logic [7:0] A_CKP  = 8'h20;
	localparam logic [7:0] A_STAT = 8'h24;
	localparam logic [7:0] A_IST  = 8'h28;
	localparam logic [7:0] A_IMSK = 8'h2c;
	localparam logic [7:0] A_CNT  = 8'h30;
	localparam logic [7:0] A_UP   = 8'h4c;

	localparam int C_DIAL = 0;
	localparam int C_HUP  = 1;
	localparam int C_TXA  = 2;
	localparam int C_PRST = 3;
	localparam int C_ANS  = 4;

	localparam logic [15:0] CMD_RST = 16'h0000;
	localparam logic [15:0] CON_RST = 16'h003c;
	localparam logic [15:0] DIS_RST = 16'h0002;
	localparam logic [15:0] NOA_RST = 16'h0000;
	localparam logic [15:0] MXF_RST = 16'h0800;
	localparam logic [3:0]  RTY_RST = 4'h1;
	localparam logic [3:0]  CKP_RST = 4'hf;

	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_GOOD = 16'hf0b8;
	localparam logic [18:0] MIN_BITS = 19'h00010;

	localparam logic [1:0] RESP_OK  = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;
	localparam logic [1:0] CK_OFF   = 2'b00;
	localparam logic [1:0] CK_ON    = 2'b01;
	localparam logic [1:0] CK_UND   = 2'b11;

	localparam int E_CRC = 0;
	localparam int E_ALN = 1;
	localparam int E_SHT = 2;
	localparam int E_LNG = 3;
	localparam int E_ABT = 4;
	localparam int E_UND = 5;
	localparam int E_OAB = 6;
	localparam int NCNT  = 7;

	localparam int I_UP   = 0;
	localparam int I_FAIL = 1;
	localparam int I_BLK  = 2;
	localparam int I_RX   = 3;
	localparam int I_TX   = 4;
	localparam int NIRQ   = 5;

	typedef struct packed {
		logic clk;
		logic dat;
		logic frm;
		logic abt;
	} sdc_lnk_t;

	typedef struct packed {
		logic cts;
		logic dsr;
		logic dcd;
		logic ring;
	} sdc_mdm_t;

	typedef enum logic [2:0] {S_IDLE, S_DLY, S_CALL, S_UP, S_HUP} sdc_st_t;
endpackage

// ### rtl/sdc_cnt.sv
`timescale 1ns/1ps
module sdc_cnt
	import sdc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	input  wire logic        clr_in,
	input  wire logic        inc_in,
	output logic      [31:0] cnt_out
);
	typedef struct packed {
		logic [31:0] c;
	} sdc_cnt_st_t;

	sdc_cnt_st_t q;
	sdc_cnt_st_t d;

	always_comb begin
		d = q;
		if (clr_in) begin
			d.c = '0;
		end else if (inc_in && q.c != '1) begin
			d.c = q.c + 32'h1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else if (ce_in) begin
			q <= d;
		end
	end

	assign cnt_out = q.c;

	property p_sat;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && !clr_in && q.c == '1) |=> (q.c == '1);
	endproperty
	a_sat: assert property (p_sat) else $error("counter wrapped");
endmodule

// ### verification/sdc_far_model.sv
`timescale 1ns/1ps
module sdc_far_model
	import sdc_pkg::*;
#(
	parameter int RISE = 30,
	parameter int DROP = 40
) (
	input  wire logic clk_in,
	input  wire logic dtr_in,
	input  wire logic stb_in,
	input  wire logic ans_in,
	output sdc_mdm_t  mdm_out,
	output sdc_lnk_t  lnk_out
);
	int on_n  = 0;
	int off_n = 0;
	int dcd_n = 0;
	initial begin
		mdm_out = '0;
		lnk_out = '0;
	end
	////////////////////////////////////////////////////////////////
	// slow modem: a zero delay setting must really wait for it
	always @(posedge clk_in) begin
		if (dtr_in) begin
			off_n <= 0;
			on_n <= on_n + 1;
			if (on_n == RISE) begin
				mdm_out.cts <= 1'b1;
				mdm_out.dsr <= 1'b1;
			end
		end else begin
			on_n <= 0;
			off_n <= off_n + 1;
			if (off_n == DROP) begin
				mdm_out.cts <= 1'b0;
				mdm_out.dsr <= 1'b0;
			end
		end
		if (stb_in && ans_in)
			dcd_n <= 20;
		else if (dcd_n > 0)
			dcd_n <= dcd_n - 1;
		if (dcd_n == 1)
			mdm_out.dcd <= 1'b1;
		if (!dtr_in)
			mdm_out.dcd <= 1'b0;
		// a waiting far call rings only while terminal-ready is low
		mdm_out.ring <= ans_in && !dtr_in;
	end
	////////////////////////////////////////////////////////////////
	// link clock stands still between frames
	task automatic frame(input logic [63:0] v, input int n, input bit ab);
		lnk_out.frm = 1'b1;
		for (int i = 0; i < n; i++) begin
			lnk_out.dat = v[i];
			lnk_out.abt = ab && (i == n - 1);
			#32 lnk_out.clk = 1'b1;
			#32 lnk_out.clk = 1'b0;
		end
		// released data line shows the inverse, never a held value
		lnk_out.frm = 1'b0;
		lnk_out.abt = 1'b0;
		lnk_out.dat = ~lnk_out.dat;
		#32 lnk_out.clk = 1'b1;
		#32 lnk_out.clk = 1'b0;
	endtask
endmodule

// ### verification/serial_dial_control_rx_screen_bench.sv
`timescale 1ns/1ps
module serial_dial_control_rx_screen_bench;
	import sdc_pkg::*;
	localparam int MS = 10;
	localparam logic [7:0] RA [7] = '{A_CMD, A_CON, A_DIS, A_RTY, A_NOA, A_MXF, A_CKP};
	localparam logic [31:0] RV [7] = '{32'(CMD_RST), 32'(CON_RST), 32'(DIS_RST), 32'(RTY_RST),
		32'(NOA_RST), 32'(MXF_RST), 32'(CKP_RST)};
	localparam int FN [5] = '{32, 33, 8, 40, 32};
	logic        clk, rst_n, aw_v, w_v, b_r, ar_v, r_r, busy, und, ans, dtr_q;
	logic [31:0] aw_a, w_d, ar_a, rd;
	logic [1:0]  rs;
	logic [63:0] g, lg;
	wire         aw_r, w_r, b_v, ar_r, r_v, dtr, stb, rx_ok, txa, irq;
	wire  [1:0]  b_rs, r_rs;
	wire  [31:0] r_d;
	wire  [7:0]  dadr;
	sdc_lnk_t    lnk;
	sdc_mdm_t    mdm;
	int fail_count = 0, cmp_count = 0, cyc = 0, n_ok = 0, n_stb = 0, n_txa = 0, t_up = 0, t_stb = 0, t_dn = 0;

	sdc_top #(.MS_CYCLES(MS)) uut (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(1'b1),
		.AXI_AWVALID_IN(aw_v), .AXI_AWREADY_OUT(aw_r), .AXI_AWADDR_IN(aw_a), .AXI_WVALID_IN(w_v),
		.AXI_WREADY_OUT(w_r), .AXI_WDATA_IN(w_d), .AXI_WSTRB_IN(4'hf), .AXI_BVALID_OUT(b_v),
		.AXI_BREADY_IN(b_r), .AXI_BRESP_OUT(b_rs), .AXI_ARVALID_IN(ar_v), .AXI_ARREADY_OUT(ar_r),
		.AXI_ARADDR_IN(ar_a), .AXI_RVALID_OUT(r_v), .AXI_RREADY_IN(r_r), .AXI_RDATA_OUT(r_d),
		.AXI_RRESP_OUT(r_rs), .LINK_IN(lnk), .MODEM_IN(mdm), .DTR_OUT(dtr), .DIAL_STB_OUT(stb),
		.DIAL_ADDR_OUT(dadr), .RX_OK_OUT(rx_ok), .TX_BUSY_IN(busy), .TX_UNDERRUN_IN(und),
		.TX_ABORT_OUT(txa), .IRQ_OUT(irq));
	sdc_far_model fm (.clk_in(clk), .dtr_in(dtr), .stb_in(stb), .ans_in(ans), .mdm_out(mdm), .lnk_out(lnk));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc <= cyc + 1;
		dtr_q <= dtr;
		n_ok <= n_ok + (rx_ok === 1'b1);
		n_txa <= n_txa + (txa === 1'b1);
		if (stb === 1'b1) begin
			n_stb <= n_stb + 1;
			t_stb <= cyc;
		end
		if (dtr === 1'b1 && dtr_q !== 1'b1)
			t_up <= cyc;
		if (dtr !== 1'b1 && dtr_q === 1'b1)
			t_dn <= cyc;
		if (cyc == 40000) begin
			fail_count++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		cmp_count++;
		if (v !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		aw_a <= {24'h0, a};
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		do begin
			@(posedge clk);
			if (aw_v && aw_r)
				aw_v <= 1'b0;
			if (w_v && w_r)
				w_v <= 1'b0;
		end while (b_v !== 1'b1);
		rs = b_rs;
		b_r <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		ar_a <= {24'h0, a};
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do begin
			@(posedge clk);
			if (ar_v && ar_r)
				ar_v <= 1'b0;
		end while (r_v !== 1'b1);
		rd = r_d;
		rs = r_rs;
		r_r <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rdr(a);
		chk(nm, e, rd);
	endtask
	task automatic dial(input logic [7:0] a);
		wr(A_ADR, {24'h0, a});
		wr(A_CTRL, 32'h1);
	endtask
	function automatic logic [15:0] fcs(input logic [63:0] d, input int n);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 0; i < n; i++)
			c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'h8408 : 16'h0000);
		return ~c;
	endfunction
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, aw_v, w_v, b_r, ar_v, r_r, busy, und, ans, dtr_q} = '0;
		{aw_a, w_d, ar_a} = '0;
		g = {32'h0, fcs(64'h1234, 16), 16'h1234};
		lg = {24'h0, fcs(64'habcdef, 24), 24'habcdef};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++)
			rchk(RA[i], RV[i], "default");
		for (int i = 0; i < NCNT; i++)
			rchk(A_CNT + 8'(4 * i), 32'h0, "counter");
		wr(A_CNT, 32'h1);
		chk("bresp", {30'h0, RESP_ERR}, {30'h0, rs});
		rdr(8'hfc);
		chk("rresp", {30'h0, RESP_ERR}, {30'h0, rs});
		wr(A_CKP, 32'h5);
		rdr(A_STAT);
		chk("circuits", 32'h0330, rd & 32'hff0);
		$display("registers done");
		// max size 4 bytes: the 4-byte good frame is the boundary that must pass
		wr(A_MXF, 32'h4);
		fm.frame(g, 32, 1'b0);
		repeat (8) @(posedge clk);
		chk("rx ok", 32'h1, n_ok);
		for (int i = 0; i < 5; i++) begin
			fm.frame(i == 0 ? g ^ 64'h10000 : (i == 3 ? lg : g), FN[i], i == 4);
			repeat (8) @(posedge clk);
			rchk(A_CNT + 8'(4 * i), 32'h1, "rx error");
		end
		chk("rx ok", 32'h1, n_ok);
		wr(A_IMSK, 32'h8);
		chk("irq", 32'h1, {31'h0, irq});
		rchk(A_IST, 32'h8, "irq status");
		chk("irq", 32'h0, {31'h0, irq});
		$display("receive done");
		busy <= 1'b1;
		und <= 1'b1;
		repeat (2) @(posedge clk);
		und <= 1'b0;
		wr(A_CTRL, 32'h4);
		busy <= 1'b0;
		wr(A_CTRL, 32'h4);
		repeat (4) @(posedge clk);
		chk("aborts sent", 32'h1, n_txa);
		rchk(A_CNT + 8'(4 * E_UND), 32'h2, "underruns");
		rchk(A_CNT + 8'(4 * E_OAB), 32'h1, "output aborts");
		rchk(A_IST, 32'h10, "irq status");
		wr(A_CTRL, 32'h8);
		for (int i = 0; i < NCNT; i++)
			rchk(A_CNT + 8'(4 * i), 32'h0, "cleared");
		rchk(A_UP, 32'h0, "uptime");
		$display("transmit done");
		wr(A_CMD, 32'h2);
		wr(A_CON, 32'h1);
		wr(A_DIS, 32'h0);
		wr(A_NOA, 32'h5);
		dial(8'h21);
		while (n_stb == 0) @(posedge clk);
		while (dtr === 1'b1) @(posedge clk);
		// let the drop time settle before it is read
		@(posedge clk);
		chk("command delay", 32'h1, 32'(t_stb - t_up >= MS && t_stb - t_up <= 2 * MS + 6));
		chk("dial address", 32'h21, {24'h0, dadr});
		chk("connect limit", 32'h1, 32'(t_dn - t_stb >= 999 * MS && t_dn - t_stb <= 1000 * MS + 10));
		rchk(A_IST, 32'h2, "irq status");
		repeat (100) @(posedge clk);
		dial(8'h21);
		repeat (100) @(posedge clk);
		chk("strobes", 32'h1, n_stb);
		rdr(A_STAT);
		chk("blocked", 32'h1, {31'h0, rd[3]});
		$display("failed call done");
		ans <= 1'b1;
		wr(A_CMD, 32'h0);
		wr(A_CON, 32'h0);
		dial(8'h33);
		while (n_stb < 2) @(posedge clk);
		chk("cts wait", 32'h1, 32'(t_stb - t_up >= 30));
		repeat (60) @(posedge clk);
		rdr(A_STAT);
		chk("state", 32'h3, {29'h0, rd[2:0]});
		wr(A_CTRL, 32'h2);
		do rdr(A_STAT); while (rd[2:0] !== 3'h0);
		chk("disconnect wait", 32'h1, 32'(cyc - t_dn >= 40));
		$display("answered call done");
		// incoming ring: answer after clear-to-send, no dial strobe, zero connect keeps waiting
		wr(A_CTRL, 32'h10);
		repeat (60) @(posedge clk);
		rdr(A_STAT);
		chk("answer state", 32'h2, {29'h0, rd[2:0]});
		chk("answer strobes", 32'h2, n_stb);
		$display("incoming call done");
		print_verdict();
	end
endmodule
